/* File: core/flk_regs.svh */
// Purpose: offsets, fields, reset values and codes of the flash guard.
// Assumes: 8-bit special-function register bus.
// Notes:   values are the hardware's; header holds definitions only.
`ifndef FLK_REGS_SVH
`define FLK_REGS_SVH

`define FLK_ADDR_SCALE      8'hb6
`define FLK_ADDR_KEY        8'hb7
`define FLK_KEY_FIRST       8'ha5
`define FLK_KEY_SECOND      8'hf1
`define FLK_OSE_BIT         7
`define FLK_RTS_BIT         4
`define FLK_SCALE_RESET     8'h80
`define FLK_SCALE_MASK      8'h90
`define FLK_CODE_LOCKED     2'h0
`define FLK_CODE_FIRST      2'h1
`define FLK_CODE_OPEN       2'h2
`define FLK_CODE_BARRED     2'h3
`define FLK_PULSE_CYCLES    1

`endif

/* File: core/flk_pkg.sv */
// Purpose: types of the flash guard.
// Assumes: codes are gray along locked, first, open.
// Notes:   barred is the terminal lockout state.
`default_nettype none
package flk_pkg;
  typedef enum logic [1:0] {
    FLK_LOCKED = 2'h0,
    FLK_FIRST  = 2'h1,
    FLK_OPEN   = 2'h3,
    FLK_BARRED = 2'h2
  } flk_lock_t;
endpackage
`default_nettype wire

/* File: core/flk_sense_pulse.sv */
// Purpose: sense amplifier enable per program-store read.
// Assumes: i_read is one cycle per read.
// Notes:   one-shot adds a one-cycle pulse; otherwise sense enable alone.
`include "flk_regs.svh"
`default_nettype none
module flk_sense_pulse #(
  parameter int PULSE_CYCLES = `FLK_PULSE_CYCLES
) (
  input  wire logic i_clk,        // core clock
  input  wire logic i_rst_n,      // async reset, low
  input  wire logic i_read,       // read strobe
  input  wire logic i_one_shot,   // one-shot mode
  output logic      o_sense_en,   // sense amp enable
  output logic      o_sense_pulse // one-shot form
);
  typedef struct packed {
    logic sense;
    logic pulse;
  } flk_sp_state_t;

  flk_sp_state_t st_reg;
  flk_sp_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.sense = i_read;
    st_next.pulse = i_read & i_one_shot;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sense_en    = st_reg.sense;
  assign o_sense_pulse = st_reg.pulse;

  a_sense_follows: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_read |=> o_sense_en) else $error("sense not enabled on read");
  a_shot_pulse: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_read && i_one_shot |=> o_sense_pulse)
    else $error("no one-shot pulse on read");
  a_full_cycle: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_read && !i_one_shot |=> o_sense_en && !o_sense_pulse)
    else $error("full cycle read flagged as one-shot");
endmodule
`default_nettype wire

/* File: core/flk_guard.sv */
// Purpose: flash key lock, lockout, read timing and one-shot control.
// Assumes: bus strobes are one cycle; op done is one cycle.
// Notes:   lockout ends only at reset.
`include "flk_regs.svh"
`default_nettype none
module flk_guard (
  input  wire logic       i_clk,        // core clock
  input  wire logic       i_rst_n,      // async reset, low
  input  wire logic [7:0] i_sfr_addr,   // register address
  input  wire logic [7:0] i_sfr_wdata,  // write data
  input  wire logic       i_sfr_wr,     // write strobe
  input  wire logic       i_sfr_rd,     // read strobe
  input  wire logic       i_store_wr_en,// program store write enable
  input  wire logic       i_store_er_en,// program store erase enable
  input  wire logic       i_move_wr,    // move-write strobe
  input  wire logic       i_op_done,    // flash op complete
  input  wire logic       i_read,       // program store read
  output logic      [7:0] o_sfr_rdata,  // read data
  output logic            o_flash_wr,   // byte write start
  output logic            o_flash_erase,// page erase start
  output logic            o_xdata_wr,   // external data write
  output logic            o_unlocked,   // permission granted
  output logic            o_read_timing,// timing select
  output logic            o_sense_en,   // sense amp enable
  output logic            o_sense_pulse // one-shot pulse
);
  typedef struct packed {
    flk_pkg::flk_lock_t lock;
    logic               busy;
    logic               ose;
    logic               rts;
    logic [7:0]         rdata;
    logic               fwr;
    logic               fer;
    logic               xwr;
    logic               unl;
  } flk_state_t;

  localparam logic [7:0] SCALE_RST = `FLK_SCALE_RESET;
  // reset state: locked, no lockout, scale bits from their reset value
  localparam flk_state_t ST_RESET = '{
    lock:  flk_pkg::FLK_LOCKED,
    busy:  1'b0,
    ose:   SCALE_RST[`FLK_OSE_BIT],
    rts:   SCALE_RST[`FLK_RTS_BIT],
    rdata: 8'h00,
    fwr:   1'b0,
    fer:   1'b0,
    xwr:   1'b0,
    unl:   1'b0
  };

  flk_state_t st_reg;
  flk_state_t st_next;
  logic [1:0] code;

  always_comb begin
    case (st_reg.lock)
      flk_pkg::FLK_LOCKED: code = `FLK_CODE_LOCKED;
      flk_pkg::FLK_FIRST:  code = `FLK_CODE_FIRST;
      flk_pkg::FLK_OPEN:   code = `FLK_CODE_OPEN;
      flk_pkg::FLK_BARRED: code = `FLK_CODE_BARRED;
      default:             code = `FLK_CODE_BARRED;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.fwr = 1'b0;
    st_next.fer = 1'b0;
    st_next.xwr = 1'b0;
    if (i_sfr_wr && i_sfr_addr == `FLK_ADDR_SCALE) begin
      st_next.ose = i_sfr_wdata[`FLK_OSE_BIT];
      st_next.rts = i_sfr_wdata[`FLK_RTS_BIT];
    end
    if (i_sfr_wr && i_sfr_addr == `FLK_ADDR_KEY) begin
      case (st_reg.lock)
        flk_pkg::FLK_LOCKED: begin
          if (i_sfr_wdata == `FLK_KEY_FIRST) begin
            st_next.lock = flk_pkg::FLK_FIRST;
          end else begin
            st_next.lock = flk_pkg::FLK_BARRED;
          end
        end
        flk_pkg::FLK_FIRST: begin
          if (i_sfr_wdata == `FLK_KEY_SECOND) begin
            st_next.lock = flk_pkg::FLK_OPEN;
          end else begin
            st_next.lock = flk_pkg::FLK_BARRED;
          end
        end
        flk_pkg::FLK_OPEN:   st_next.lock = flk_pkg::FLK_BARRED;
        flk_pkg::FLK_BARRED: st_next.lock = flk_pkg::FLK_BARRED;
        default:             st_next.lock = flk_pkg::FLK_BARRED;
      endcase
    end
    if (i_move_wr) begin
      if (!i_store_wr_en) begin
        st_next.xwr = 1'b1;
      end else if (st_reg.lock == flk_pkg::FLK_OPEN && !st_reg.busy) begin
        st_next.busy = 1'b1;
        st_next.fer  = i_store_er_en;
        st_next.fwr  = ~i_store_er_en;
      end else begin
        st_next.lock = flk_pkg::FLK_BARRED;
      end
    end
    if (st_reg.busy && i_op_done) begin
      st_next.busy = 1'b0;
      if (st_next.lock == flk_pkg::FLK_OPEN) begin
        st_next.lock = flk_pkg::FLK_LOCKED;
      end
    end
    // permission flag kept as a flop so the output is registered
    st_next.unl = (st_next.lock == flk_pkg::FLK_OPEN);
    st_next.rdata = 8'h00;
    if (i_sfr_rd && i_sfr_addr == `FLK_ADDR_KEY) begin
      st_next.rdata = {6'h00, code};
    end else if (i_sfr_rd && i_sfr_addr == `FLK_ADDR_SCALE) begin
      st_next.rdata = {st_reg.ose, 2'h0, st_reg.rts, 4'h0};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sfr_rdata   = st_reg.rdata;
  assign o_flash_wr    = st_reg.fwr;
  assign o_flash_erase = st_reg.fer;
  assign o_xdata_wr    = st_reg.xwr;
  assign o_unlocked    = st_reg.unl;
  assign o_read_timing = st_reg.rts;

  flk_sense_pulse u_sense (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_read        (i_read),
    .i_one_shot    (st_reg.ose),
    .o_sense_en    (o_sense_en),
    .o_sense_pulse (o_sense_pulse)
  );

  a_barred_sticks: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_reg.lock == flk_pkg::FLK_BARRED |=> st_reg.lock == flk_pkg::FLK_BARRED)
    else $error("lockout left without reset");
  a_bad_key_bars: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_sfr_wr && i_sfr_addr == `FLK_ADDR_KEY &&
    st_reg.lock == flk_pkg::FLK_LOCKED && i_sfr_wdata != `FLK_KEY_FIRST
    |=> st_reg.lock == flk_pkg::FLK_BARRED) else $error("no lockout");
  a_open_needs_keys: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_unlocked) |-> $past(st_reg.lock) == flk_pkg::FLK_FIRST)
    else $error("unlock without first key");
  a_write_needs_open: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_flash_wr || o_flash_erase) |-> $past(o_unlocked))
    else $error("flash op while locked");
  a_locked_attempt: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_move_wr && i_store_wr_en && !o_unlocked
    |=> st_reg.lock == flk_pkg::FLK_BARRED) else $error("attempt missed");
  a_revoke_done: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_reg.busy && i_op_done && o_unlocked && !i_sfr_wr && !i_move_wr
    |=> st_reg.lock == flk_pkg::FLK_LOCKED) else $error("not revoked");
  a_erase_page: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_move_wr && i_store_wr_en && i_store_er_en && o_unlocked && !st_reg.busy
    |=> o_flash_erase && !o_flash_wr) else $error("erase not issued");
  a_xdata_route: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_move_wr && !i_store_wr_en |=> o_xdata_wr && !o_flash_wr)
    else $error("move-write misrouted");
  a_key_readback: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_sfr_rd && i_sfr_addr == `FLK_ADDR_KEY |=> o_sfr_rdata[7:2] == 6'h00 &&
    o_sfr_rdata[1:0] == $past(code)) else $error("bad key readback");
  a_timing_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_sfr_wr && i_sfr_addr == `FLK_ADDR_SCALE
    |=> o_read_timing == $past(i_sfr_wdata[`FLK_RTS_BIT]))
    else $error("timing select lost");
  a_first_key_step: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_sfr_wr && i_sfr_addr == `FLK_ADDR_KEY && !i_move_wr &&
    st_reg.lock == flk_pkg::FLK_LOCKED && i_sfr_wdata == `FLK_KEY_FIRST
    |=> st_reg.lock == flk_pkg::FLK_FIRST)
    else $error("first key not taken");
  a_second_key_opens: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_sfr_wr && i_sfr_addr == `FLK_ADDR_KEY && !i_move_wr &&
    st_reg.lock == flk_pkg::FLK_FIRST && i_sfr_wdata == `FLK_KEY_SECOND
    |=> o_unlocked)
    else $error("second key did not unlock");
  a_open_key_bars: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_sfr_wr && i_sfr_addr == `FLK_ADDR_KEY &&
    st_reg.lock == flk_pkg::FLK_OPEN
    |=> st_reg.lock == flk_pkg::FLK_BARRED)
    else $error("key write while open not barred");
  a_busy_move_bars: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_move_wr && i_store_wr_en && st_reg.busy
    |=> st_reg.lock == flk_pkg::FLK_BARRED && !o_flash_wr && !o_flash_erase)
    else $error("second op while busy not barred");
  a_barred_no_op: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_reg.lock == flk_pkg::FLK_BARRED |=> !o_flash_wr && !o_flash_erase)
    else $error("flash op during lockout");
  a_one_op_each: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_flash_wr || o_flash_erase) |=> !(o_flash_wr || o_flash_erase))
    else $error("more than one op per unlock");
  a_open_reads: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_sfr_rd && i_sfr_addr == `FLK_ADDR_KEY && o_unlocked
    |=> o_sfr_rdata == {6'h00, `FLK_CODE_OPEN})
    else $error("open state read wrong");
  a_barred_reads: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_sfr_rd && i_sfr_addr == `FLK_ADDR_KEY &&
    st_reg.lock == flk_pkg::FLK_BARRED
    |=> o_sfr_rdata == {6'h00, `FLK_CODE_BARRED})
    else $error("lockout state read wrong");
  a_first_reads: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_sfr_rd && i_sfr_addr == `FLK_ADDR_KEY &&
    st_reg.lock == flk_pkg::FLK_FIRST
    |=> o_sfr_rdata == {6'h00, `FLK_CODE_FIRST})
    else $error("first key state read wrong");
  a_scale_readback: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_sfr_rd && i_sfr_addr == `FLK_ADDR_SCALE
    |=> (o_sfr_rdata & ~`FLK_SCALE_MASK) == 8'h00 &&
    o_sfr_rdata[`FLK_RTS_BIT] == $past(o_read_timing))
    else $error("scale readback wrong");
endmodule
`default_nettype wire

/* File: bench/flk_core_model.sv */
// Purpose: core side model issuing register, move and read strobes.
// Assumes: one strobe per call, driven at the falling edge.
// Notes:   idle address and data show the inverse of the last value.
`default_nettype none
module flk_core_model (
  input  wire logic       i_clk,   // core clock
  output logic      [7:0] o_addr,  // register address
  output logic      [7:0] o_wdata, // write data
  output logic            o_wr,    // write strobe
  output logic            o_rd,    // read strobe
  output logic            o_move,  // move-write strobe
  output logic            o_done,  // op complete
  output logic            o_read   // store read
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {o_addr, o_wdata} = '0;
    {o_wr, o_rd, o_move, o_done, o_read} = '0;
  end
  // kinds: 0 write, 1 read, 2 move, 3 done, 4 store read
  task automatic strobe(input int k, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    case (k)
      0: o_wr = 1'b1;
      1: o_rd = 1'b1;
      2: o_move = 1'b1;
      3: o_done = 1'b1;
      default: o_read = 1'b1;
    endcase
    @(negedge i_clk);
    {o_wr, o_rd, o_move, o_done, o_read} = '0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule
`default_nettype wire

/* File: bench/flk_guard_tb_top.sv */
// Purpose: self-checking bench for the flash guard.
// Assumes: core model drives strobes; answers sampled a cycle later.
// Notes:   resets in mid-run clear the lockout.
`include "flk_regs.svh"
`default_nettype none
module flk_guard_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_n, wen, een, wr, rd, mv, dn, srd;
  logic [7:0] addr, wd, rdata;
  logic       fwr, fer, xwr, unl, rts, sen, spl;
  int         fails = 0;
  int         check_count = 0;
  flk_core_model flk_core_model_i (.i_clk(clk), .o_addr(addr), .o_wdata(wd),
    .o_wr(wr), .o_rd(rd), .o_move(mv), .o_done(dn), .o_read(srd));
  flk_guard flk_guard_i (.i_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr),
    .i_sfr_wdata(wd), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_store_wr_en(wen),
    .i_store_er_en(een), .i_move_wr(mv), .i_op_done(dn), .i_read(srd),
    .o_sfr_rdata(rdata), .o_flash_wr(fwr), .o_flash_erase(fer),
    .o_xdata_wr(xwr), .o_unlocked(unl), .o_read_timing(rts),
    .o_sense_en(sen), .o_sense_pulse(spl));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string n, input logic [7:0] s,
                       input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic reset_dut;
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    flk_core_model_i.strobe(0, a, d);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    flk_core_model_i.strobe(1, a, 8'h00);
    check("register read", rdata, e);
  endtask
  task automatic rkey(input logic [1:0] c);
    rreg(`FLK_ADDR_KEY, {6'h00, c});
  endtask
  task automatic move(input logic w, input logic e, input logic [2:0] x);
    wen = w;
    een = e;
    flk_core_model_i.strobe(2, 8'h00, 8'h5a);
    check("flash ops", {5'h00, fwr, fer, xwr}, {5'h00, x});
    wen = 1'b0;
    een = 1'b0;
  endtask
  task automatic sense(input logic [1:0] x);
    flk_core_model_i.strobe(4, 8'h00, 8'h00);
    check("sense", {6'h00, sen, spl}, {6'h00, x});
  endtask
  task automatic unlock;
    wreg(`FLK_ADDR_KEY, `FLK_KEY_FIRST);
    wreg(`FLK_ADDR_KEY, `FLK_KEY_SECOND);
  endtask
  initial begin
    #20000;
    fails++;
    complete_run;
  end
  initial begin
    {wen, een} = 2'b00;
    reset_dut;
    rreg(`FLK_ADDR_SCALE, `FLK_SCALE_RESET);
    rkey(`FLK_CODE_LOCKED);
    check("timing", {7'h00, rts}, 8'h00);
    rreg(8'h40, 8'h00);
    wreg(`FLK_ADDR_SCALE, 8'hff);
    rreg(`FLK_ADDR_SCALE, `FLK_SCALE_MASK);
    check("timing", {7'h00, rts}, 8'h01);
    wreg(`FLK_ADDR_SCALE, 8'h00);
    sense(2'b10);
    wreg(`FLK_ADDR_SCALE, 8'h80);
    sense(2'b11);
    $display("test scale and sense done");
    wreg(`FLK_ADDR_KEY, `FLK_KEY_FIRST);
    rkey(`FLK_CODE_FIRST);
    wreg(`FLK_ADDR_KEY, `FLK_KEY_SECOND);
    rkey(`FLK_CODE_OPEN);
    check("unlocked", {7'h00, unl}, 8'h01);
    move(1'b1, 1'b0, 3'b100);
    flk_core_model_i.strobe(3, 8'h00, 8'h00);
    rkey(`FLK_CODE_LOCKED);
    check("unlocked", {7'h00, unl}, 8'h00);
    unlock;
    move(1'b1, 1'b1, 3'b010);
    flk_core_model_i.strobe(3, 8'h00, 8'h00);
    move(1'b0, 1'b0, 3'b001);
    rkey(`FLK_CODE_LOCKED);
    $display("test unlock done");
    move(1'b1, 1'b0, 3'b000);
    rkey(`FLK_CODE_BARRED);
    unlock;
    rkey(`FLK_CODE_BARRED);
    reset_dut;
    rkey(`FLK_CODE_LOCKED);
    wreg(`FLK_ADDR_KEY, `FLK_KEY_SECOND);
    rkey(`FLK_CODE_BARRED);
    reset_dut;
    wreg(`FLK_ADDR_KEY, `FLK_KEY_FIRST);
    wreg(`FLK_ADDR_KEY, `FLK_KEY_FIRST);
    rkey(`FLK_CODE_BARRED);
    reset_dut;
    wreg(`FLK_ADDR_KEY, 8'h3c);
    rkey(`FLK_CODE_BARRED);
    reset_dut;
    unlock;
    wreg(`FLK_ADDR_KEY, `FLK_KEY_FIRST);
    rkey(`FLK_CODE_BARRED);
    reset_dut;
    unlock;
    move(1'b1, 1'b0, 3'b100);
    rkey(`FLK_CODE_OPEN);
    move(1'b1, 1'b0, 3'b000);
    rkey(`FLK_CODE_BARRED);
    reset_dut;
    rreg(`FLK_ADDR_SCALE, `FLK_SCALE_RESET);
    $display("test lockout done");
    complete_run;
  end
endmodule
`default_nettype wire
